/* File: tlbma_pkg.sv */
// Purpose: Shared constants, field positions and carriers for the translation miss assist.
// Assumes: Register bit positions are little-endian indices; architectural bit b maps to index 31-b.
// Notes: Overview list follows.
// Overview of operation
// - Fetch buffer miss vectors to 0x1000
// - Load operand buffer miss vectors to 0x1100
// - Store miss or clean-hit store vectors 0x1200
// - Capture full 32-bit effective address on miss
// - Operand miss address always big-endian form
// - Miss address registers ignore software writes
// - Build match word from segment and address
// - Match valid bit set, segment identifier copied
// - Match hash bit cleared, top six page index bits copied
// - Compute primary and secondary group addresses
// - Group address: origin, hashed bits, zero low
// - Entry-write loads match and second word
// - Second word field layout, reserved reads zero
// - Miss sets scratch bank select bit
// - Trap return restores state, clears scratch bank
// - Save condition field zero in bits 0-3
// - Saved bit 13 marks fetch miss
// - Saved bit 15 marks load data miss
// - Saved bit 14 holds replacement way
// - Saved bit 12 holds selected protection key
// - User access to assist registers traps
// - Every exception clears both translation enables
package tlbma_pkg;

    localparam logic [15:0] TLBMA_VEC_FETCH = 16'h1000;
    localparam logic [15:0] TLBMA_VEC_LOAD  = 16'h1100;
    localparam logic [15:0] TLBMA_VEC_STORE = 16'h1200;

    // Saved-state word fields (architectural bits 0-3, 12, 13, 14, 15)
    localparam int TLBMA_SAV_COND_HI = 31;
    localparam int TLBMA_SAV_COND_LO = 28;
    localparam int TLBMA_SAV_KEY     = 19;
    localparam int TLBMA_SAV_FETCH   = 18;
    localparam int TLBMA_SAV_WAY     = 17;
    localparam int TLBMA_SAV_LOAD    = 16;

    // Machine state word fields
    localparam int TLBMA_MSW_SCRATCH = 17;
    localparam int TLBMA_MSW_USER    = 14;
    localparam int TLBMA_MSW_FXLATE  = 5;
    localparam int TLBMA_MSW_OXLATE  = 4;

    // Match word fields
    localparam int TLBMA_MW_VALID = 31;
    localparam int TLBMA_MW_SEG_HI = 30;
    localparam int TLBMA_MW_SEG_LO = 7;
    localparam int TLBMA_MW_HASH  = 6;
    localparam int TLBMA_EA_SPI_HI = 27;
    localparam int TLBMA_EA_SPI_LO = 22;

    // Page index and entry index within the effective address
    localparam int TLBMA_EA_PI_HI  = 27;
    localparam int TLBMA_EA_PI_LO  = 12;
    localparam int TLBMA_EA_IDX_HI = 16;
    localparam int TLBMA_EA_IDX_LO = 12;

    // Second word: page number 0-19, referenced 23, changed 24, attributes 25-28, protection 30-31
    localparam logic [31:0] TLBMA_SW_MASK = 32'hfffff1fb;
    localparam int TLBMA_SW_CHANGED = 7;

    localparam logic [31:0] TLBMA_RESET_WORD = 32'h00000000;
    localparam logic [2:0]  TLBMA_MUNGE_BYTE = 3'h7;
    localparam logic [2:0]  TLBMA_MUNGE_HALF = 3'h6;
    localparam logic [2:0]  TLBMA_MUNGE_WORD = 3'h4;
    localparam logic [2:0]  TLBMA_MUNGE_DBL  = 3'h0;

    typedef enum logic [1:0] {
        TLBMA_SIZE_BYTE = 2'b00,
        TLBMA_SIZE_HALF = 2'b01,
        TLBMA_SIZE_WORD = 2'b10,
        TLBMA_SIZE_DBL  = 2'b11
    } tlbma_size_t;

    typedef enum logic [3:0] {
        TLBMA_SEL_OP_MISS  = 4'h0,
        TLBMA_SEL_FE_MISS  = 4'h1,
        TLBMA_SEL_OP_MATCH = 4'h2,
        TLBMA_SEL_FE_MATCH = 4'h3,
        TLBMA_SEL_GROUP1   = 4'h4,
        TLBMA_SEL_GROUP2   = 4'h5,
        TLBMA_SEL_SECOND   = 4'h6,
        TLBMA_SEL_SAVED    = 4'h7
    } tlbma_sel_t;

    typedef struct packed {
        logic        fetch_miss;
        logic        load_miss;
        logic        store_miss;
        logic        store_hit;
        logic        hit_changed;
        logic        le_mode;
        tlbma_size_t size;
        logic [31:0] ea;
    } tlbma_miss_t;

    typedef struct packed {
        logic [23:0] segment_identifier;
        logic        supervisor_key;
        logic        user_key;
    } tlbma_seg_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        tlbma_sel_t  sel;
        logic [31:0] wdata;
    } tlbma_spr_req_t;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic [31:0] ea;
    } tlbma_entry_req_t;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        way;
        logic [4:0]  index;
        logic [31:0] word0;
        logic [31:0] word1;
    } tlbma_tlb_wr_t;

endpackage : tlbma_pkg

/* File: tlbma_group_addr.sv */
// Purpose: Page-table-group address from one hash of the miss address.
// Assumes: Table base word holds origin in its upper half and mask in its low nine bits.
// Notes: Purely combinational; instantiated once per hash.
`timescale 1ns/1ps
module tlbma_group_addr
    import tlbma_pkg::*;
#(
    parameter bit SECONDARY = 1'b0
) (
    input  wire logic [23:0] segment_identifier_i,
    input  wire logic [31:0] ea_i,
    input  wire logic [31:0] table_base_word_i,
    output logic      [31:0] group_addr_o
);

    logic [18:0] primary;
    logic [18:0] hash;

    // Page index is 16 bits, so the top three hash bits come from the segment alone
    assign primary = segment_identifier_i[18:0] ^ {3'h0, ea_i[TLBMA_EA_PI_HI:TLBMA_EA_PI_LO]};
    assign hash    = SECONDARY ? ~primary : primary;

    assign group_addr_o = {table_base_word_i[31:25],
                           table_base_word_i[24:16] | (hash[18:10] & table_base_word_i[8:0]),
                           hash[9:0],
                           6'h00};

endmodule : tlbma_group_addr

/* File: tlbma_core.sv */
// Purpose: Translation miss assist: capture, match word, group addresses, saved state, entry writes.
// Assumes: Miss, register access, entry-write, trap-return and exception inputs are single-cycle pulses.
// Notes: All outputs are registered; a miss in the same cycle as a software write wins.
`timescale 1ns/1ps
module tlbma_core
    import tlbma_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    input  wire tlbma_miss_t      miss_i,
    input  wire tlbma_seg_t       seg_i,
    input  wire logic [3:0]       cond_field_zero_i,
    input  wire logic             lru_way_i,
    input  wire logic [31:0]      table_base_word_i,
    input  wire logic             exc_other_i,
    input  wire logic             rfi_i,
    input  wire logic             msw_wr_i,
    input  wire logic [31:0]      msw_wdata_i,
    input  wire tlbma_spr_req_t   spr_i,
    input  wire tlbma_entry_req_t entry_i,
    output logic                  exc_take_o,
    output logic [15:0]           exc_vector_o,
    output logic                  priv_exc_o,
    output logic                  spr_ack_o,
    output logic [31:0]           spr_rdata_o,
    output tlbma_tlb_wr_t         tlb_wr_o,
    output logic [31:0]           machine_state_word_o,
    output logic                  scratch_bank_select_o
);

    typedef struct packed {
        logic [31:0]   operand_miss_address;
        logic [31:0]   fetch_miss_address;
        logic [31:0]   operand_match_word;
        logic [31:0]   fetch_match_word;
        logic [31:0]   first_group_addr;
        logic [31:0]   second_group_addr;
        logic [31:0]   second_word;
        logic [31:0]   saved_state_word;
        logic [31:0]   machine_state_word;
        logic          exc_take;
        logic [15:0]   exc_vector;
        logic          priv_exc;
        logic          spr_ack;
        logic [31:0]   spr_rdata;
        tlbma_tlb_wr_t tlb_wr;
    } tlbma_state_t;

    tlbma_state_t state;
    tlbma_state_t next_state;

    logic        take_fetch;
    logic        take_load;
    logic        take_store;
    logic        take_any;
    logic        user_level;
    logic [2:0]  munge;
    logic [31:0] ea_be;
    logic [31:0] match_word;
    logic [31:0] group1;
    logic [31:0] group2;

    // One hash result per group address; both come from the address as captured
    tlbma_group_addr #(
        .SECONDARY (1'b0)
    ) u_group1 (
        .segment_identifier_i (seg_i.segment_identifier),
        .ea_i                 (ea_be),
        .table_base_word_i    (table_base_word_i),
        .group_addr_o         (group1)
    );

    tlbma_group_addr #(
        .SECONDARY (1'b1)
    ) u_group2 (
        .segment_identifier_i (seg_i.segment_identifier),
        .ea_i                 (ea_be),
        .table_base_word_i    (table_base_word_i),
        .group_addr_o         (group2)
    );

    // Register read mux; codes outside the map read as zero
    function automatic logic [31:0] read_reg(input tlbma_state_t s, input tlbma_sel_t sel);
        logic [31:0] v;
        v = TLBMA_RESET_WORD;
        case (sel)
            TLBMA_SEL_OP_MISS:  v = s.operand_miss_address;
            TLBMA_SEL_FE_MISS:  v = s.fetch_miss_address;
            TLBMA_SEL_OP_MATCH: v = s.operand_match_word;
            TLBMA_SEL_FE_MATCH: v = s.fetch_match_word;
            TLBMA_SEL_GROUP1:   v = s.first_group_addr;
            TLBMA_SEL_GROUP2:   v = s.second_group_addr;
            TLBMA_SEL_SECOND:   v = s.second_word;
            TLBMA_SEL_SAVED:    v = s.saved_state_word;
            default:            v = TLBMA_RESET_WORD;
        endcase
        return v;
    endfunction : read_reg

    // A fetch miss ranks above a data miss if both arrive together
    always_comb begin
        take_fetch = miss_i.fetch_miss;
        take_load  = miss_i.load_miss & ~take_fetch;
        take_store = (miss_i.store_miss | (miss_i.store_hit & ~miss_i.hit_changed))
                     & ~take_fetch & ~miss_i.load_miss;
        take_any   = take_fetch | take_load | take_store;
        user_level = state.machine_state_word[TLBMA_MSW_USER];
    end

    // Little-endian mode munges the low address bits; undo that for data accesses
    always_comb begin
        unique case (miss_i.size)
            TLBMA_SIZE_BYTE: munge = TLBMA_MUNGE_BYTE;
            TLBMA_SIZE_HALF: munge = TLBMA_MUNGE_HALF;
            TLBMA_SIZE_WORD: munge = TLBMA_MUNGE_WORD;
            TLBMA_SIZE_DBL:  munge = TLBMA_MUNGE_DBL;
        endcase
        ea_be = miss_i.ea;
        if (!take_fetch && miss_i.le_mode) begin
            ea_be[2:0] = miss_i.ea[2:0] ^ munge;
        end
    end

    always_comb begin
        match_word                                = TLBMA_RESET_WORD;
        match_word[TLBMA_MW_VALID]                = 1'b1;
        match_word[TLBMA_MW_SEG_HI:TLBMA_MW_SEG_LO] = seg_i.segment_identifier;
        match_word[TLBMA_MW_HASH]                 = 1'b0;
        match_word[5:0] = ea_be[TLBMA_EA_SPI_HI:TLBMA_EA_SPI_LO];
    end

    always_comb begin
        next_state             = state;
        next_state.exc_take    = 1'b0;
        next_state.priv_exc    = 1'b0;
        next_state.spr_ack     = 1'b0;
        next_state.tlb_wr.valid = 1'b0;

        // Register access: answered one cycle later, or trapped at user level
        if (spr_i.valid) begin
            next_state.spr_ack = 1'b1;
            if (user_level) begin
                next_state.priv_exc  = 1'b1;
                next_state.spr_rdata = TLBMA_RESET_WORD;
            end else begin
                next_state.spr_rdata = spr_i.write ? TLBMA_RESET_WORD : read_reg(state, spr_i.sel);
                if (spr_i.write) begin
                    // Miss, match and group registers keep their value under writes
                    if (spr_i.sel == TLBMA_SEL_SECOND) begin
                        next_state.second_word = spr_i.wdata & TLBMA_SW_MASK;
                    end else if (spr_i.sel == TLBMA_SEL_SAVED) begin
                        next_state.saved_state_word = spr_i.wdata;
                    end
                end
            end
        end

        // Entry write takes the way bit as it stands now, so software may override it
        if (entry_i.valid) begin
            if (user_level) begin
                next_state.priv_exc = 1'b1;
            end else begin
                next_state.tlb_wr.valid = 1'b1;
                next_state.tlb_wr.fetch = entry_i.fetch;
                next_state.tlb_wr.way   = state.saved_state_word[TLBMA_SAV_WAY];
                next_state.tlb_wr.index = entry_i.ea[TLBMA_EA_IDX_HI:TLBMA_EA_IDX_LO];
                next_state.tlb_wr.word0 = entry_i.fetch ? state.fetch_match_word
                                                        : state.operand_match_word;
                next_state.tlb_wr.word1 = state.second_word;
            end
        end

        if (msw_wr_i) begin
            next_state.machine_state_word = msw_wdata_i;
        end

        // Saved word bits 12-15 overlap live state bits, so only the low half is restored
        if (rfi_i) begin
            next_state.machine_state_word[15:0] = state.saved_state_word[15:0];
            next_state.machine_state_word[TLBMA_MSW_SCRATCH] = 1'b0;
        end

        if (exc_other_i) begin
            next_state.saved_state_word[15:0] = state.machine_state_word[15:0];
            next_state.machine_state_word[TLBMA_MSW_FXLATE] = 1'b0;
            next_state.machine_state_word[TLBMA_MSW_OXLATE] = 1'b0;
        end

        // Miss last: its captures win over any software write in the same cycle
        if (take_any) begin
            next_state.exc_take = 1'b1;
            if (take_fetch) begin
                next_state.exc_vector         = TLBMA_VEC_FETCH;
                next_state.fetch_miss_address = ea_be;
                next_state.fetch_match_word   = match_word;
            end else begin
                next_state.exc_vector           = take_load ? TLBMA_VEC_LOAD : TLBMA_VEC_STORE;
                next_state.operand_miss_address = ea_be;
                next_state.operand_match_word   = match_word;
            end
            next_state.first_group_addr  = group1;
            next_state.second_group_addr = group2;

            next_state.saved_state_word[15:0] = state.machine_state_word[15:0];
            next_state.saved_state_word[TLBMA_SAV_COND_HI:TLBMA_SAV_COND_LO] = cond_field_zero_i;
            next_state.saved_state_word[27:20] = 8'h00;
            next_state.saved_state_word[TLBMA_SAV_KEY] = user_level ? seg_i.user_key
                                                                    : seg_i.supervisor_key;
            next_state.saved_state_word[TLBMA_SAV_FETCH] = take_fetch;
            next_state.saved_state_word[TLBMA_SAV_WAY]   = lru_way_i;
            next_state.saved_state_word[TLBMA_SAV_LOAD]  = take_load;

            next_state.machine_state_word[TLBMA_MSW_SCRATCH] = 1'b1;
            next_state.machine_state_word[TLBMA_MSW_FXLATE]  = 1'b0;
            next_state.machine_state_word[TLBMA_MSW_OXLATE]  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign exc_take_o            = state.exc_take;
    assign exc_vector_o          = state.exc_vector;
    assign priv_exc_o            = state.priv_exc;
    assign spr_ack_o             = state.spr_ack;
    assign spr_rdata_o           = state.spr_rdata;
    assign tlb_wr_o              = state.tlb_wr;
    assign machine_state_word_o  = state.machine_state_word;
    assign scratch_bank_select_o = state.machine_state_word[TLBMA_MSW_SCRATCH];

endmodule : tlbma_core

/* File: tlbma_core_sva.sv */
// Purpose: Port-level assertions for the translation miss assist core.
// Assumes: Every answer is registered and appears one cycle after its request edge.
// Notes: The user level is read from the machine state word output itself.
`timescale 1ns/1ps
module tlbma_core_sva
    import tlbma_pkg::*;
(
    input wire logic             clk_sys_i,
    input wire logic             resetn_i,
    input wire tlbma_miss_t      miss_i,
    input wire logic             exc_other_i,
    input wire logic             rfi_i,
    input wire tlbma_spr_req_t   spr_i,
    input wire tlbma_entry_req_t entry_i,
    input wire logic             exc_take_o,
    input wire logic [15:0]      exc_vector_o,
    input wire logic             priv_exc_o,
    input wire logic [31:0]      spr_rdata_o,
    input wire tlbma_tlb_wr_t    tlb_wr_o,
    input wire logic [31:0]      machine_state_word_o,
    input wire logic             scratch_bank_select_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic miss;
    logic user;
    assign miss = miss_i.fetch_miss | miss_i.load_miss | miss_i.store_miss | (miss_i.store_hit & ~miss_i.hit_changed);
    assign user = machine_state_word_o[TLBMA_MSW_USER];
    AST_MISS_TAKE: assert property (miss |=> exc_take_o) else $error("miss not taken");
    AST_NO_CAUSE: assert property (!miss |=> !exc_take_o) else $error("exception without a miss");
    AST_VEC_FETCH: assert property (miss_i.fetch_miss |=> exc_vector_o == TLBMA_VEC_FETCH)
        else $error("wrong fetch vector");
    AST_VEC_LOAD: assert property (miss_i.load_miss && !miss_i.fetch_miss |=> exc_vector_o == TLBMA_VEC_LOAD)
        else $error("wrong load vector");
    AST_VEC_STORE: assert property (miss && !miss_i.fetch_miss && !miss_i.load_miss
        |=> exc_vector_o == TLBMA_VEC_STORE) else $error("wrong store vector");
    AST_SCRATCH_ON: assert property (miss |=> scratch_bank_select_o
        && machine_state_word_o[5:4] == 2'b00) else $error("scratch bank or translation bits wrong after miss");
    AST_RFI_OFF: assert property (rfi_i && !miss |=> !scratch_bank_select_o) else $error("scratch bank kept");
    AST_EXC_XLATE: assert property (exc_other_i |=> machine_state_word_o[5:4] == 2'b00)
        else $error("translation left on");
    AST_PRIV_SPR: assert property (spr_i.valid && user |=> priv_exc_o && spr_rdata_o == 32'h0)
        else $error("user register access not trapped");
    AST_ENTRY_WR: assert property (entry_i.valid && !user |=> tlb_wr_o.valid
        && tlb_wr_o.fetch == $past(entry_i.fetch) && tlb_wr_o.index == $past(entry_i.ea[16:12]))
        else $error("entry write wrong");
    AST_ENTRY_USER: assert property (entry_i.valid && user |=> priv_exc_o && !tlb_wr_o.valid)
        else $error("user entry write not trapped");
    cover property (miss_i.store_hit && !miss_i.hit_changed);
    cover property (rfi_i);
    cover property (entry_i.valid && !user);
endmodule : tlbma_core_sva

bind tlbma_core tlbma_core_sva u_sva (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .miss_i(miss_i),
    .exc_other_i(exc_other_i), .rfi_i(rfi_i), .spr_i(spr_i), .entry_i(entry_i), .exc_take_o(exc_take_o),
    .exc_vector_o(exc_vector_o), .priv_exc_o(priv_exc_o), .spr_rdata_o(spr_rdata_o), .tlb_wr_o(tlb_wr_o),
    .machine_state_word_o(machine_state_word_o), .scratch_bank_select_o(scratch_bank_select_o));

/* File: tb_tlbma.sv */
// Purpose: Directed bench for the translation miss assist core.
// Assumes: Answers appear one cycle after the request edge.
// Notes: Each request has an idle edge before it, so back-to-back timing is left to the checker.
`timescale 1ns/1ps
module testbench
    import tlbma_pkg::*;
;
    logic             clk_sys_i, resetn_i, lru_way_i, exc_other_i, rfi_i, msw_wr_i;
    logic [3:0]       cond_field_zero_i;
    logic [31:0]      table_base_word_i, msw_wdata_i, spr_rdata_o, machine_state_word_o, ea;
    tlbma_miss_t      miss_i;
    tlbma_seg_t       seg_i;
    tlbma_spr_req_t   spr_i;
    tlbma_entry_req_t entry_i;
    tlbma_size_t      msz;
    logic             exc_take_o, priv_exc_o, spr_ack_o, scratch_bank_select_o;
    logic [15:0]      exc_vector_o;
    tlbma_tlb_wr_t    tlb_wr_o;
    int               fail_count, checks_done;

    tlbma_core u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .miss_i(miss_i), .seg_i(seg_i),
        .cond_field_zero_i(cond_field_zero_i), .lru_way_i(lru_way_i), .table_base_word_i(table_base_word_i),
        .exc_other_i(exc_other_i), .rfi_i(rfi_i), .msw_wr_i(msw_wr_i), .msw_wdata_i(msw_wdata_i),
        .spr_i(spr_i), .entry_i(entry_i), .exc_take_o(exc_take_o), .exc_vector_o(exc_vector_o),
        .priv_exc_o(priv_exc_o), .spr_ack_o(spr_ack_o), .spr_rdata_o(spr_rdata_o), .tlb_wr_o(tlb_wr_o),
        .machine_state_word_o(machine_state_word_o), .scratch_bank_select_o(scratch_bank_select_o));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic report_and_stop;
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Inputs move 1 ns after the edge so no race with the design's sampling
    task automatic step;
        @(posedge clk_sys_i);
        #1;
    endtask : step

    task automatic spr(input logic w, input tlbma_sel_t s, input logic [31:0] d);
        step();
        spr_i = '{1'b1, w, s, d};
        step();
        spr_i = '0;
    endtask : spr

    task automatic rd(input tlbma_sel_t s, input logic [31:0] e);
        spr(1'b0, s, 32'h0);
        chk("spr_ack", 32'h1, {31'h0, spr_ack_o});
        chk(s.name(), e, spr_rdata_o);
    endtask : rd

    // Kind bits: fetch, load, store, store_hit, hit_changed
    task automatic miss(input logic [4:0] k, input logic le, input logic [31:0] a);
        step();
        miss_i = '{k[4], k[3], k[2], k[1], k[0], le, msz, a};
        step();
        miss_i = '0;
        chk("exc_take", {31'h0, |k[4:2] | (k[1] & ~k[0])}, {31'h0, exc_take_o});
    endtask : miss

    task automatic ent(input logic f, input logic [31:0] a, input logic v, input logic [31:0] w0);
        step();
        entry_i = '{1'b1, f, a};
        step();
        entry_i = '0;
        chk("tlb_valid", {31'h0, v}, {31'h0, tlb_wr_o.valid});
        chk("priv_exc", {31'h0, ~v}, {31'h0, priv_exc_o});
        if (v) begin
            chk("tlb_way", 32'h1, {31'h0, tlb_wr_o.way});
            chk("tlb_index", {27'h0, a[16:12]}, {27'h0, tlb_wr_o.index});
            chk("tlb_word0", w0, tlb_wr_o.word0);
            chk("tlb_word1", 32'hfffff1fb, tlb_wr_o.word1);
        end
    endtask : ent

    function automatic logic [31:0] mw(input logic [31:0] a);
        return {1'b1, seg_i.segment_identifier, 1'b0, a[27:22]};
    endfunction : mw

    function automatic logic [31:0] grp(input logic [31:0] a, input logic s);
        logic [18:0] h;
        h = seg_i.segment_identifier[18:0] ^ {3'b0, a[27:12]};
        if (s) h = ~h;
        return {table_base_word_i[31:25], table_base_word_i[24:16] | (h[18:10] & table_base_word_i[8:0]),
            h[9:0], 6'h0};
    endfunction : grp

    initial begin
        #200000;
        fail_count++;
        $display("MISMATCH run_time expected done seen timeout");
        report_and_stop();
    end

    initial begin
        fail_count = 0;
        checks_done = 0;
        {exc_other_i, rfi_i, msw_wr_i, msw_wdata_i} = '0;
        miss_i = '0;
        msz = TLBMA_SIZE_WORD;
        spr_i = '0;
        entry_i = '0;
        seg_i = '{24'ha5c3e1, 1'b1, 1'b0};
        cond_field_zero_i = 4'ha;
        lru_way_i = 1'b1;
        table_base_word_i = 32'h12b4_01ff;
        resetn_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1 resetn_i = 1'b1;
        chk("msw_reset", 32'h0, machine_state_word_o);
        ea = 32'h3c5a_7123;
        miss(5'b01000, 1'b0, ea);
        chk("vector", 32'h1100, {16'h0, exc_vector_o});
        chk("scratch", 32'h1, {31'h0, scratch_bank_select_o});
        chk("msw", 32'h0002_0000, machine_state_word_o);
        rd(TLBMA_SEL_OP_MISS, ea);
        rd(TLBMA_SEL_OP_MATCH, mw(ea));
        rd(TLBMA_SEL_GROUP1, grp(ea, 1'b0));
        rd(TLBMA_SEL_GROUP2, grp(ea, 1'b1));
        rd(TLBMA_SEL_SAVED, 32'ha00b_0000);
        spr(1'b1, TLBMA_SEL_OP_MISS, 32'hffff_ffff);
        rd(TLBMA_SEL_OP_MISS, ea);
        rd(tlbma_sel_t'(4'h9), 32'h0);
        miss(5'b00100, 1'b1, 32'h0040_1006);
        chk("vector", 32'h1200, {16'h0, exc_vector_o});
        rd(TLBMA_SEL_OP_MISS, 32'h0040_1002);
        rd(TLBMA_SEL_SAVED, 32'ha00a_0000);
        // Every access size of the little-endian undo
        msz = TLBMA_SIZE_BYTE;
        miss(5'b00100, 1'b1, 32'h0040_1006);
        rd(TLBMA_SEL_OP_MISS, 32'h0040_1001);
        msz = TLBMA_SIZE_HALF;
        miss(5'b00100, 1'b1, 32'h0040_1006);
        rd(TLBMA_SEL_OP_MISS, 32'h0040_1000);
        msz = TLBMA_SIZE_DBL;
        miss(5'b00100, 1'b1, 32'h0040_1006);
        rd(TLBMA_SEL_OP_MISS, 32'h0040_1006);
        msz = TLBMA_SIZE_WORD;
        miss(5'b00010, 1'b0, ea);
        miss(5'b00011, 1'b0, 32'h0);
        lru_way_i = 1'b0;
        miss(5'b10000, 1'b1, 32'hf00d_5a5c);
        chk("vector", 32'h1000, {16'h0, exc_vector_o});
        rd(TLBMA_SEL_FE_MISS, 32'hf00d_5a5c);
        rd(TLBMA_SEL_FE_MATCH, mw(32'hf00d_5a5c));
        rd(TLBMA_SEL_SAVED, 32'ha00c_0000);
        spr(1'b1, TLBMA_SEL_SECOND, 32'hffff_ffff);
        rd(TLBMA_SEL_SECOND, 32'hfffff1fb);
        // Software overrides the replacement way before the entry writes
        spr(1'b1, TLBMA_SEL_SAVED, 32'h0002_0030);
        ent(1'b1, 32'hf00d_5a5c, 1'b1, mw(32'hf00d_5a5c));
        ent(1'b0, ea, 1'b1, mw(ea));
        step();
        rfi_i = 1'b1;
        step();
        rfi_i = 1'b0;
        chk("scratch", 32'h0, {31'h0, scratch_bank_select_o});
        chk("msw", 32'h0000_0030, machine_state_word_o);
        step();
        exc_other_i = 1'b1;
        step();
        exc_other_i = 1'b0;
        chk("msw", 32'h0, machine_state_word_o);
        msw_wdata_i = 32'h0000_4000;
        step();
        msw_wr_i = 1'b1;
        step();
        msw_wr_i = 1'b0;
        spr(1'b0, TLBMA_SEL_SAVED, 32'h0);
        chk("priv_exc", 32'h1, {31'h0, priv_exc_o});
        chk("rdata", 32'h0, spr_rdata_o);
        ent(1'b1, ea, 1'b0, 32'h0);
        seg_i = '{24'ha5c3e1, 1'b0, 1'b1};
        miss(5'b01000, 1'b0, ea);
        msw_wdata_i = 32'h0;
        step();
        msw_wr_i = 1'b1;
        step();
        msw_wr_i = 1'b0;
        rd(TLBMA_SEL_SAVED, 32'ha009_4000);
        report_and_stop();
    end
endmodule : testbench
